// File: hw/persistent_switch_sequencer.sv
// Purpose: persistent switch enter/exit sequencer
// Assumes: keys are one-cycle pulses from same-clock logic; sense flags are pins
// Notes:   nonvolatile store is external; stored values are captured after reset
`default_nettype none
module persistent_switch_sequencer
    import psw_seq_pkg::*;
#(
    parameter int unsigned CUR_W = 24,
    parameter int unsigned TICKS = TICK_CYCLES
) (
    input  wire  logic             clock,
    input  wire  logic             rst,
    input  wire  keys_t            keys,
    input  wire  sense_t           senseAsync,
    input  wire  rampMode_t        rampMode,
    input  wire  logic             atTarget,
    input  wire  logic             defaultView,
    input  wire  logic [CUR_W-1:0] supplyCurrent,
    input  wire  logic [SEC_W-1:0] switchCoolTime,
    input  wire  logic [SEC_W-1:0] switchHeatTime,
    input  wire  logic             switchTransitionMethod,
    input  wire  logic             storedPersist,
    input  wire  logic [CUR_W-1:0] storedCurrent,
    output logic                   heaterOn,
    output logic                   persistLed,
    output logic                   beep,
    output logic                   mismatchErr,
    output supplyCmd_t             supplyCmd,
    output logic                   useSwitchRate,
    output logic [CUR_W-1:0]       rampTarget,
    output logic                   rampInhibit,
    output seqState_t              seqState,
    output logic [SEC_W-1:0]       countdown,
    output logic                   persistSave,
    output logic [CUR_W-1:0]       recordedCurrent
);
    initial begin
        if (CUR_W < 1 || TICKS < 2) $error("bad parameter");
    end

    // ----------------------------------------------------------------
    // sense synchronisers
    // ----------------------------------------------------------------
    sense_t senseMeta_r;
    sense_t sense_r;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            senseMeta_r <= '0;
            sense_r     <= '0;
        end else begin
            senseMeta_r <= senseAsync;
            sense_r     <= senseMeta_r;
        end
    end

    // ----------------------------------------------------------------
    // state and tick
    // ----------------------------------------------------------------
    seqState_t         state_r;
    seqState_t         state_nxt;
    logic [31:0]       tick_r;
    logic              tickPulse;
    logic [SEC_W-1:0]  secs_r;
    logic [SEC_W-1:0]  zeroSecs_r;
    logic              captureDone_r;
    logic [CUR_W-1:0]  preCool_r;
    logic              entering;
    logic              timeUp;
    logic              coolDone;
    logic              heatDone;

    assign entering  = (state_nxt != state_r);
    assign tickPulse = (tick_r == 32'(TICKS - 1));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_r <= '0;
        end else if (entering || tickPulse ||
                     (switchTransitionMethod && !sense_r.varianceZero)) begin
            tick_r <= '0;
        end else begin
            tick_r <= tick_r + 32'h0000_0001;
        end
    end

    // elapsed seconds in the present state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            secs_r <= SEC_ZERO;
        end else if (entering) begin
            secs_r <= SEC_ZERO;
        end else if (tickPulse && secs_r != '1) begin
            secs_r <= secs_r + SEC_ONE;
        end
    end

    // seconds with variance held at zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            zeroSecs_r <= SEC_ZERO;
        end else if (entering || !sense_r.varianceZero) begin
            zeroSecs_r <= SEC_ZERO;
        end else if (tickPulse && zeroSecs_r != '1) begin
            zeroSecs_r <= zeroSecs_r + SEC_ONE;
        end
    end

    always_comb begin
        timeUp   = 1'b0;
        coolDone = 1'b0;
        heatDone = 1'b0;
        if (state_r == ST_COOL) begin
            timeUp = (secs_r >= switchCoolTime);
        end else if (state_r == ST_HEAT) begin
            timeUp = (secs_r >= switchHeatTime);
        end
        if (switchTransitionMethod) begin
            coolDone = (zeroSecs_r >= SEC_W'(VAR_HOLD_SEC));
            heatDone = !sense_r.varianceZero;
        end else begin
            coolDone = timeUp;
            heatDone = timeUp;
        end
    end

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (keys.switchControl && !keys.shiftSwitch) begin
                    if (persistLed) begin
                        state_nxt = ST_EXIT_CONF;
                    end else if (atTarget && defaultView &&
                                 (rampMode == MODE_HOLDING || rampMode == MODE_PAUSED)) begin
                        state_nxt = ST_ENT_CONF;
                    end
                end
            end
            ST_ENT_CONF: begin
                if (keys.escape) state_nxt = ST_IDLE;
                else if (keys.enter) state_nxt = ST_COOL;
            end
            ST_COOL: if (coolDone) state_nxt = ST_TO_ZERO;
            ST_TO_ZERO: begin
                if (sense_r.voltageHigh) state_nxt = ST_RECOVER;
                else if (sense_r.rampDone) state_nxt = ST_PERSIST;
            end
            ST_RECOVER: begin
                if (keys.rampPause) state_nxt = ST_REC_PAUSE;
                else if (sense_r.rampDone) state_nxt = ST_PSW_ERR;
            end
            ST_REC_PAUSE: state_nxt = ST_IDLE;
            ST_PSW_ERR: if (keys.enter) state_nxt = ST_IDLE;
            ST_PERSIST: begin
                if (keys.escape) begin
                    state_nxt = ST_IDLE;
                end else if (keys.switchControl && !keys.shiftSwitch) begin
                    state_nxt = ST_EXIT_CONF;
                end
            end
            ST_POWER_UP: if (keys.enter) state_nxt = ST_PERSIST;
            ST_EXIT_CONF: begin
                if (keys.escape) state_nxt = ST_IDLE;
                else if (keys.enter) state_nxt = ST_MATCH;
            end
            ST_MATCH: if (sense_r.rampDone) state_nxt = ST_HEAT;
            ST_HEAT: begin
                if (sense_r.voltageHigh) state_nxt = ST_IDLE;
                else if (heatDone) state_nxt = ST_DRIVEN;
            end
            ST_DRIVEN: if (keys.enter) state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // one-shot power-up check of the stored state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r       <= ST_IDLE;
            captureDone_r <= 1'b0;
        end else if (!captureDone_r) begin
            captureDone_r <= 1'b1;
            state_r       <= storedPersist ? ST_POWER_UP : ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // currents
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            preCool_r       <= '0;
            recordedCurrent <= '0;
        end else if (!captureDone_r) begin
            recordedCurrent <= storedCurrent;
        end else if (state_r == ST_ENT_CONF && keys.enter) begin
            preCool_r       <= supplyCurrent;
            recordedCurrent <= supplyCurrent;
        end
    end

    // ----------------------------------------------------------------
    // heater, indicator, beep
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            heaterOn <= 1'b1;
        end else if (!captureDone_r) begin
            heaterOn <= !storedPersist;
        end else if (keys.switchControl && keys.shiftSwitch && state_r == ST_IDLE) begin
            heaterOn <= !heaterOn;
        end else if (state_r == ST_ENT_CONF && keys.enter) begin
            heaterOn <= 1'b0;
        end else if (state_r == ST_TO_ZERO && sense_r.voltageHigh) begin
            heaterOn <= 1'b1;
        end else if (state_r == ST_MATCH && sense_r.rampDone) begin
            heaterOn <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            persistLed <= 1'b0;
        end else if (!captureDone_r) begin
            persistLed <= 1'b0;
        end else if (state_r == ST_COOL && coolDone) begin
            persistLed <= 1'b1;
        end else if (state_r == ST_POWER_UP && keys.enter) begin
            persistLed <= 1'b1;
        end else if (state_nxt == ST_RECOVER || state_nxt == ST_DRIVEN) begin
            persistLed <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            beep        <= 1'b0;
            mismatchErr <= 1'b0;
        end else begin
            beep <= sense_r.voltageHigh &&
                    (state_r == ST_TO_ZERO || state_r == ST_HEAT);
            if (state_r == ST_HEAT && sense_r.voltageHigh) begin
                mismatchErr <= 1'b1;
            end else if (state_r == ST_EXIT_CONF && keys.enter) begin
                mismatchErr <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // supply commands
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            supplyCmd     <= RAMP_HOLD;
            useSwitchRate <= 1'b0;
            rampTarget    <= '0;
        end else begin
            case (state_nxt)
                ST_TO_ZERO: begin
                    supplyCmd     <= RAMP_PSU;
                    useSwitchRate <= 1'b1;
                    rampTarget    <= '0;
                end
                ST_RECOVER: begin
                    supplyCmd     <= RAMP_PSU;
                    useSwitchRate <= 1'b1;
                    rampTarget    <= preCool_r;
                end
                ST_MATCH: begin
                    supplyCmd     <= RAMP_PSU;
                    useSwitchRate <= 1'b1;
                    rampTarget    <= recordedCurrent;
                end
                ST_HEAT, ST_REC_PAUSE, ST_PSW_ERR, ST_DRIVEN: begin
                    supplyCmd     <= RAMP_PAUSE;
                    useSwitchRate <= 1'b0;
                end
                default: begin
                    supplyCmd     <= (supplyCmd == RAMP_PAUSE && !keys.rampPause) ?
                                     RAMP_PAUSE : RAMP_HOLD;
                    useSwitchRate <= 1'b0;
                end
            endcase
        end
    end

    assign rampInhibit = (state_r == ST_COOL || state_r == ST_HEAT);
    assign seqState    = state_r;
    assign persistSave = persistLed;

    always_comb begin
        countdown = SEC_ZERO;
        if (!switchTransitionMethod && state_r == ST_COOL && switchCoolTime > secs_r) begin
            countdown = switchCoolTime - secs_r;
        end else if (!switchTransitionMethod && state_r == ST_HEAT &&
                     switchHeatTime > secs_r) begin
            countdown = switchHeatTime - secs_r;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_ramp_inhibit: assert property (@(posedge clock) disable iff (rst)
        (state_r == ST_COOL || state_r == ST_HEAT) |-> rampInhibit && supplyCmd != RAMP_PSU)
        else $error("ramp not inhibited during switch transition");
    a_heater_cool: assert property (@(posedge clock) disable iff (rst)
        (state_r == ST_COOL) |-> !heaterOn)
        else $error("heater on while cooling");
    a_recover_heat: assert property (@(posedge clock) disable iff (rst)
        (state_r == ST_TO_ZERO && sense_r.voltageHigh) |=> heaterOn && beep)
        else $error("no heater and beep on switch failure");
    a_zero_target: assert property (@(posedge clock) disable iff (rst)
        (state_r == ST_COOL && coolDone) |=> persistLed && rampTarget == '0)
        else $error("cooling done without zero ramp");
    a_pause_recov: assert property (@(posedge clock) disable iff (rst)
        (state_r == ST_RECOVER && keys.rampPause) |=> supplyCmd == RAMP_PAUSE)
        else $error("recovery not paused");
    a_confirm_wait: assert property (@(posedge clock) disable iff (rst)
        (state_r == ST_ENT_CONF && !keys.enter && !keys.escape) |=> state_r == ST_ENT_CONF)
        else $error("left confirm without key");
    a_mismatch_flag: assert property (@(posedge clock) disable iff (rst)
        (state_r == ST_HEAT && sense_r.voltageHigh) |=> mismatchErr && state_r == ST_IDLE)
        else $error("mismatch not flagged");
    a_enter_gate: assert property (@(posedge clock) disable iff (rst)
        (state_r == ST_IDLE && state_nxt == ST_ENT_CONF) |-> atTarget && defaultView)
        else $error("enter accepted off target");
    a_toggle_only: assert property (@(posedge clock) disable iff (rst)
        (state_r == ST_IDLE && keys.switchControl && keys.shiftSwitch && captureDone_r)
        |=> heaterOn != $past(heaterOn) && state_r == ST_IDLE)
        else $error("shifted key did more than toggle");
endmodule : persistent_switch_sequencer
`default_nettype wire

// File: hw/psw_seq_pkg.sv
// Purpose: shared constants and carriers for the persistent switch sequencer
// Assumes: 125 MHz system clock
// Notes:   timing counts derived from rates, never typed as cycles
`default_nettype none
package psw_seq_pkg;
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned TICK_SEC      = 1;
    localparam int unsigned TICK_CYCLES   = CLK_HZ * TICK_SEC;
    localparam int unsigned VAR_HOLD_SEC  = 5;
    localparam int unsigned SEC_W         = 16;
    localparam logic [SEC_W-1:0] SEC_ZERO = 16'h0000;
    localparam logic [SEC_W-1:0] SEC_ONE  = 16'h0001;

    typedef enum logic [1:0] {
        RAMP_HOLD  = 2'h0,
        RAMP_PSU   = 2'h1,
        RAMP_PAUSE = 2'h2
    } supplyCmd_t;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_ENT_CONF  = 4'h1,
        ST_COOL      = 4'h3,
        ST_TO_ZERO   = 4'h2,
        ST_PERSIST   = 4'h6,
        ST_EXIT_CONF = 4'h7,
        ST_MATCH     = 4'h5,
        ST_HEAT      = 4'h4,
        ST_DRIVEN    = 4'hC,
        ST_RECOVER   = 4'hD,
        ST_PSW_ERR   = 4'hF,
        ST_POWER_UP  = 4'hE,
        ST_REC_PAUSE = 4'hA
    } seqState_t;

    typedef enum logic [3:0] {
        MODE_OTHER   = 4'h0,
        MODE_HOLDING = 4'h1,
        MODE_PAUSED  = 4'h2,
        MODE_ZEROING = 4'h3,
        MODE_ZERO    = 4'h4,
        MODE_HEATING = 4'h5,
        MODE_COOLING = 4'h6
    } rampMode_t;

    typedef struct packed {
        logic switchControl;
        logic shiftSwitch;
        logic enter;
        logic escape;
        logic rampPause;
    } keys_t;

    typedef struct packed {
        logic voltageHigh;
        logic varianceZero;
        logic rampDone;
    } sense_t;
endpackage : psw_seq_pkg
`default_nettype wire

// File: test/supply_ramp_model.sv
// Purpose: supply ramp controller and magnet sense front end facing the sequencer
// Assumes: a steady ramp command completes after rampCycles clocks
// Notes:   fault and variance levels come from the bench
`default_nettype none
module supply_ramp_model
    import psw_seq_pkg::*;
#(
    parameter int unsigned CUR_W = 24
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire supplyCmd_t       supplyCmd,
    input  wire logic             rampInhibit,
    input  wire logic [CUR_W-1:0] rampTarget,
    input  wire logic [7:0]       rampCycles,
    input  wire logic             faultHigh,
    input  wire logic             varZero,
    output var  sense_t           sense
);
    logic [7:0]       rampCnt_r;
    logic [CUR_W-1:0] lastTarget_r;
    // ------------------------------
    // ramp progress
    // ------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rampCnt_r    <= 8'h00;
            lastTarget_r <= '0;
        end else begin
            lastTarget_r <= rampTarget;
            if (supplyCmd != RAMP_PSU || rampInhibit || rampTarget != lastTarget_r) begin
                rampCnt_r <= 8'h00;
            end else if (rampCnt_r != rampCycles) begin
                rampCnt_r <= rampCnt_r + 8'h01;
            end
        end
    end
    always_comb begin
        sense.rampDone     = (supplyCmd == RAMP_PSU) && (rampCnt_r == rampCycles);
        sense.voltageHigh  = faultHigh;
        sense.varianceZero = varZero;
    end
endmodule : supply_ramp_model
`default_nettype wire

// File: test/persistent_switch_sequencer_tb.sv
// Purpose: self-checking bench for the persistent switch sequencer
// Assumes: TICKS shortened to 10 clocks per second
// Notes:   keys are one-cycle pulses from the bench
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %0h got %0h", n, (e), (a)); end end
module persistent_switch_sequencer_tb
    import psw_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned TK = 10;
    localparam logic [4:0] K_SC = 5'h10, K_SH = 5'h18, K_EN = 5'h04, K_ES = 5'h02, K_RP = 5'h01;
    logic clock, rst, atTarget, defaultView, vMode, storedPersist, faultHigh, varZero;
    logic heaterOn, persistLed, beep, mismatchErr, useSwitchRate, rampInhibit, persistSave;
    keys_t keys;
    sense_t sense;
    rampMode_t rampMode;
    supplyCmd_t supplyCmd;
    seqState_t seqState;
    logic [23:0] supplyCurrent, storedCurrent, rampTarget, recordedCurrent;
    logic [15:0] coolT, heatT, countdown;
    logic [7:0] rampCycles;
    int error_cnt, compares, cycles, waited;
    persistent_switch_sequencer #(.CUR_W(24), .TICKS(TK)) DUT (.clock(clock), .rst(rst),
        .keys(keys), .senseAsync(sense), .rampMode(rampMode), .atTarget(atTarget),
        .defaultView(defaultView), .supplyCurrent(supplyCurrent), .switchCoolTime(coolT),
        .switchHeatTime(heatT), .switchTransitionMethod(vMode), .storedPersist(storedPersist),
        .storedCurrent(storedCurrent), .heaterOn(heaterOn), .persistLed(persistLed),
        .beep(beep), .mismatchErr(mismatchErr), .supplyCmd(supplyCmd),
        .useSwitchRate(useSwitchRate), .rampTarget(rampTarget), .rampInhibit(rampInhibit),
        .seqState(seqState), .countdown(countdown), .persistSave(persistSave),
        .recordedCurrent(recordedCurrent));
    supply_ramp_model #(.CUR_W(24)) far (.clock(clock), .rst(rst), .supplyCmd(supplyCmd),
        .rampInhibit(rampInhibit), .rampTarget(rampTarget), .rampCycles(rampCycles),
        .faultHigh(faultHigh), .varZero(varZero), .sense(sense));
    // ------------------------------
    // clock and timeout
    // ------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            error_cnt++;
            finish_test();
        end
    end
    // ------------------------------
    // shared tasks
    // ------------------------------
    task automatic finish_test();
        $display("mismatches %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    task automatic press(input logic [4:0] v);
        @(posedge clock);
        keys <= keys_t'(v);
        @(posedge clock);
        keys <= '0;
        #1;
    endtask : press
    task automatic waitSt(input seqState_t s, input int lim);
        waited = 0;
        while (seqState !== s && waited < lim) begin
            @(posedge clock);
            #1;
            waited++;
        end
        `CHK("state", s, seqState)
    endtask : waitSt
    task automatic doReset();
        @(posedge clock);
        rst <= 1'b1;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask : doReset
    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_refuse();
        rampMode <= MODE_OTHER;
        press(K_SC);
        `CHK("state", ST_IDLE, seqState)
        rampMode <= MODE_PAUSED;
        defaultView <= 1'b0;
        press(K_SC);
        `CHK("state", ST_IDLE, seqState)
        defaultView <= 1'b1;
        press(K_SC);
        `CHK("state", ST_ENT_CONF, seqState)
        press(K_ES);
        `CHK("state", ST_IDLE, seqState)
    endtask : t_refuse
    task automatic t_toggle();
        logic h;
        h = heaterOn;
        press(K_SH);
        `CHK("heater", ~h, heaterOn)
        `CHK("state", ST_IDLE, seqState)
        `CHK("cmd", RAMP_HOLD, supplyCmd)
        press(K_SH);
        `CHK("heater", h, heaterOn)
    endtask : t_toggle
    task automatic t_enter();
        supplyCurrent <= 24'h00_1234;
        press(K_SC);
        press(K_EN);
        `CHK("state", ST_COOL, seqState)
        `CHK("heater", 1'b0, heaterOn)
        `CHK("count", 16'h0003, countdown)
        `CHK("inhibit", 1'b1, rampInhibit)
        repeat (TK + 2) @(posedge clock);
        #1;
        `CHK("count", 16'h0002, countdown)
        waitSt(ST_TO_ZERO, 3 * TK);
        `CHK("led", 1'b1, persistLed)
        `CHK("cmd", RAMP_PSU, supplyCmd)
        `CHK("target", 24'h00_0000, rampTarget)
        `CHK("rate", 1'b1, useSwitchRate)
        supplyCurrent <= 24'h00_0000;
        waitSt(ST_PERSIST, 20);
        `CHK("heater", 1'b0, heaterOn)
        `CHK("save", 1'b1, persistSave)
        `CHK("rec", 24'h00_1234, recordedCurrent)
    endtask : t_enter
    task automatic t_exit();
        press(K_SC);
        `CHK("state", ST_EXIT_CONF, seqState)
        press(K_ES);
        `CHK("led", 1'b1, persistLed)
        press(K_SC);
        `CHK("state", ST_EXIT_CONF, seqState)
        press(K_EN);
        `CHK("state", ST_MATCH, seqState)
        `CHK("target", 24'h00_1234, rampTarget)
        `CHK("rate", 1'b1, useSwitchRate)
        `CHK("heater", 1'b0, heaterOn)
        waitSt(ST_HEAT, 20);
        `CHK("heater", 1'b1, heaterOn)
        `CHK("count", 16'h0002, countdown)
        waitSt(ST_DRIVEN, 2 * TK + 4);
        `CHK("early", 1'b1, waited >= 2 * TK - 2)
        press(K_EN);
        `CHK("state", ST_IDLE, seqState)
        `CHK("led", 1'b0, persistLed)
        `CHK("heater", 1'b1, heaterOn)
        `CHK("cmd", RAMP_PAUSE, supplyCmd)
    endtask : t_exit
    task automatic t_fail();
        vMode <= 1'b1;
        varZero <= 1'b0;
        rampCycles <= 8'h14;
        supplyCurrent <= 24'h00_5678;
        press(K_SC);
        press(K_EN);
        repeat (6 * TK) @(posedge clock);
        #1;
        `CHK("state", ST_COOL, seqState)
        varZero <= 1'b1;
        waitSt(ST_TO_ZERO, 5 * TK + 6);
        `CHK("hold", 1'b1, waited >= 5 * TK)
        faultHigh <= 1'b1;
        waitSt(ST_RECOVER, 6);
        faultHigh <= 1'b0;
        `CHK("heater", 1'b1, heaterOn)
        `CHK("target", 24'h00_5678, rampTarget)
        `CHK("beep", 1'b1, beep)
        waitSt(ST_PSW_ERR, 40);
        press(K_EN);
        `CHK("state", ST_IDLE, seqState)
        `CHK("heater", 1'b1, heaterOn)
        `CHK("cmd", RAMP_PAUSE, supplyCmd)
        vMode <= 1'b0;
        coolT <= 16'h0001;
        press(K_SC);
        press(K_EN);
        waitSt(ST_TO_ZERO, TK + 4);
        faultHigh <= 1'b1;
        waitSt(ST_RECOVER, 6);
        faultHigh <= 1'b0;
        press(K_RP);
        `CHK("cmd", RAMP_PAUSE, supplyCmd)
        waitSt(ST_IDLE, 4);
        `CHK("cmd", RAMP_PAUSE, supplyCmd)
        press(K_RP);
        `CHK("cmd", RAMP_HOLD, supplyCmd)
        rampCycles <= 8'h03;
    endtask : t_fail
    task automatic t_powerup();
        storedPersist <= 1'b1;
        storedCurrent <= 24'h00_9abc;
        doReset();
        `CHK("state", ST_POWER_UP, seqState)
        `CHK("heater", 1'b0, heaterOn)
        press(K_EN);
        `CHK("state", ST_PERSIST, seqState)
        `CHK("led", 1'b1, persistLed)
        `CHK("rec", 24'h00_9abc, recordedCurrent)
        press(K_SC);
        press(K_EN);
        `CHK("target", 24'h00_9abc, rampTarget)
        waitSt(ST_HEAT, 20);
        faultHigh <= 1'b1;
        waitSt(ST_IDLE, 6);
        faultHigh <= 1'b0;
        `CHK("err", 1'b1, mismatchErr)
        `CHK("cmd", RAMP_PAUSE, supplyCmd)
        `CHK("beep", 1'b1, beep)
        repeat (2) @(posedge clock);
        #1;
        `CHK("cmd", RAMP_PAUSE, supplyCmd)
    endtask : t_powerup
    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        rst = 1'b1; keys = '0; rampMode = MODE_HOLDING; atTarget = 1'b1; defaultView = 1'b1;
        supplyCurrent = '0; coolT = 16'h0003; heatT = 16'h0002; vMode = 1'b0;
        storedPersist = 1'b0; storedCurrent = '0; faultHigh = 1'b0; varZero = 1'b1;
        rampCycles = 8'h03; error_cnt = 0; compares = 0; cycles = 0;
        doReset();
        `CHK("state", ST_IDLE, seqState)
        t_refuse();
        t_toggle();
        t_enter();
        t_exit();
        t_fail();
        t_powerup();
        finish_test();
    end
endmodule : persistent_switch_sequencer_tb
`default_nettype wire
